// *** common/dma_xfer_consts.vh ***
`ifndef DMA_XFER_CONSTS_VH
`define DMA_XFER_CONSTS_VH

// ****************************************
// register byte addresses
// ****************************************
`define OFF_C2CTL 32'h80000050
`define OFF_C2ADR 32'h80000054
`define OFF_C2CNT 32'h80000058
`define OFF_C2TCN 32'h8000005C
`define OFF_C3CTL 32'h80000060
`define OFF_C3ADR 32'h80000064
`define OFF_C3CNT 32'h80000068
`define OFF_C3TCN 32'h8000006C
`define OFF_C2TAD 32'h80000078
`define OFF_C3TAD 32'h8000007C

// ****************************************
// register kinds returned by the decoder
// ****************************************
`define K_CTL 3'h0
`define K_ADR 3'h1
`define K_CNT 3'h2
`define K_TCN 3'h3
`define K_TAD 3'h4

// ****************************************
// control register fields
// ****************************************
`define B_CTI 0
`define B_TTI 1
`define B_QEN 4
`define B_CTE 5
`define B_TTE 6
`define B_EN 7
`define B_RW 8
`define B_UD 9
`define B_FLY 10
`define B_LM 11
`define DW_LO 12
`define DW_HI 13
`define DRS_LO 14
`define DRS_HI 15
`define DRM_LO 16
`define DRM_HI 17
`define B_ACS 18
`define B_TERMINATE_OUTPUT_SELECT 19
`define B_EXT 20
`define WAIT_LO 21
`define WAIT_HI 23
`define CTL_RST 32'h00000000
`define CTL_WMASK 32'h00FFFFF3

// ****************************************
// encodings and constants
// ****************************************
`define DW_WORD 2'h0
`define DW_BYTE 2'h1
`define DW_HALF 2'h2
`define DW_FIX 2'h3
`define DRS_OFF 2'h0
`define STEP_B 26'h0000001
`define STEP_H 26'h0000002
`define STEP_W 26'h0000004
`define STEP_F 26'h0000000
`define MA_LM0 26'h0FFFFFF
`define MA_LM1 26'h3FFFFFF
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001
`define EDGE_QUIET 3'h4
`define QUIET_ONE 3'h1
`define TERM_ACTIVE 1'b1

`endif

// *** src/request_latch.v ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// captures one external request per channel
// ****************************************
module request_latch (
    input wire clk_i,
    input wire rst_i,
    input wire req_i,
    input wire [1:0] mode_i,
    input wire ack_i,
    input wire mode_clr_i,
    input wire take_i,
    output wire pending_o
);
`include "dma_xfer_consts.vh"

    // mode_i[1]: 1 edge, 0 level; mode_i[0]: 1 active high, 0 active low
    wire active = mode_i[0] ? req_i : ~req_i;
    reg [2:0] quiet;
    reg pending;
    wire set_edge = active && (quiet >= `EDGE_QUIET);
    // requests seen while acknowledged belong to the running transfer
    wire set = ~ack_i && (mode_i[1] ? set_edge : active);

    always @(posedge clk_i) begin
        if (rst_i) begin
            quiet <= 3'h0;
            pending <= 1'b0;
        end else begin
            if (active)
                quiet <= 3'h0;
            else if (quiet < `EDGE_QUIET)
                quiet <= quiet + `QUIET_ONE;
            // capture runs whether or not the channel is enabled
            if (mode_clr_i)
                pending <= 1'b0;
            else if (take_i)
                pending <= 1'b0;
            else if (set)
                pending <= 1'b1;
        end
    end

    assign pending_o = pending;

endmodule // request_latch

`default_nettype wire

// *** src/dma_xfer_channels.v ***
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module dma_xfer_channels (
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] adr_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    input wire we_i,
    input wire [3:0] sel_i,
    input wire cyc_i,
    input wire stb_i,
    output wire ack_o,
    input wire [3:0] transfer_request_lines_i,
    output wire [3:0] transfer_acknowledge_lines_o,
    output wire chan2_chip_select_o,
    output wire chan3_chip_select_o,
    output wire peripheral_output_enable_o,
    output wire peripheral_write_enable_o,
    output wire [23:0] periph_addr_o,
    input wire [31:0] periph_data_i,
    output wire [31:0] periph_data_o,
    output wire periph_data_oe_o,
    input wire periph_wait_i,
    input wire transfer_terminate_line_i,
    output wire transfer_terminate_line_o,
    output wire transfer_terminate_line_oe_o,
    output wire mem_req_o,
    output wire mem_we_o,
    output wire [25:0] mem_addr_o,
    output wire [1:0] mem_size_o,
    output wire [31:0] mem_wdata_o,
    input wire [31:0] mem_rdata_i,
    input wire mem_ack_i,
    input wire mem_narrow_i
);
`include "dma_xfer_consts.vh"

    localparam S_IDLE = 3'h0;
    localparam S_MEM = 3'h1;
    localparam S_P1 = 3'h2;
    localparam S_P2 = 3'h3;
    localparam S_PW = 3'h4;
    localparam S_PX = 3'h5;
    localparam S_END = 3'h6;

    // ****************************************
    // decoding helpers
    // ****************************************
    function [4:0] decode;
        input [31:0] a;
        begin
            case (a)
                `OFF_C2CTL: decode = {2'b10, `K_CTL};
                `OFF_C2ADR: decode = {2'b10, `K_ADR};
                `OFF_C2CNT: decode = {2'b10, `K_CNT};
                `OFF_C2TCN: decode = {2'b10, `K_TCN};
                `OFF_C2TAD: decode = {2'b10, `K_TAD};
                `OFF_C3CTL: decode = {2'b11, `K_CTL};
                `OFF_C3ADR: decode = {2'b11, `K_ADR};
                `OFF_C3CNT: decode = {2'b11, `K_CNT};
                `OFF_C3TCN: decode = {2'b11, `K_TCN};
                `OFF_C3TAD: decode = {2'b11, `K_TAD};
                default: decode = 5'h00;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] o;
        input [31:0] n;
        input [3:0] s;
        integer b;
        begin
            for (b = 0; b < 4; b = b + 1)
                merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
        end
    endfunction

    function [31:0] wmask;
        input [1:0] dw;
        begin
            case (dw)
                `DW_BYTE: wmask = 32'h000000FF;
                `DW_HALF: wmask = 32'h0000FFFF;
                default: wmask = 32'hFFFFFFFF;
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [31:0] ctl [0:1];
    reg [31:0] adr [0:1];
    reg [23:0] cnt [0:1];
    reg [23:0] tcn [0:1];
    reg [25:0] tad [0:1];
    reg ack;
    reg [31:0] rdat;
    reg [2:0] st;
    reg ch;
    reg phase;
    reg [3:0] pcnt;
    reg [31:0] data;
    reg term_hit;
    reg [31:0] rmux;

    // ****************************************
    // bus slave decode
    // ****************************************
    wire [4:0] dec = decode(adr_i);
    wire hit = dec[4];
    wire rch = dec[3];
    wire [2:0] kind = dec[2:0];
    wire req = cyc_i & stb_i;
    // a write lands on the edge where ack is seen high
    wire wr = req & we_i & ack & hit;
    wire [31:0] wval = merge(rmux, dat_i, sel_i);

    always @* begin
        rmux = 32'h00000000;
        if (hit) begin
            case (kind)
                `K_CTL: rmux = ctl[rch];
                `K_ADR: rmux = adr[rch];
                `K_CNT: rmux = {8'h00, cnt[rch]};
                `K_TAD: rmux = {6'h00, tad[rch]};
                default: rmux = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // current channel fields
    // ****************************************
    wire [31:0] cc = ctl[ch];
    wire [31:0] ca = adr[ch];
    wire [23:0] cn = cnt[ch];
    wire [1:0] dw = cc[`DW_HI:`DW_LO];
    wire rw = cc[`B_RW];
    wire lm = cc[`B_LM];
    wire [2:0] wcnt = cc[`WAIT_HI:`WAIT_LO];
    wire [1:0] drs_cur = cc[`DRS_HI:`DRS_LO];
    wire last_xfer = cn == `CNT_ZERO;
    wire split = (dw == `DW_WORD || dw == `DW_FIX) && mem_narrow_i;
    wire [25:0] amask = lm ? `MA_LM1 : `MA_LM0;
    wire [31:0] am32 = {6'h00, amask};
    wire [25:0] step = dw == `DW_BYTE ? `STEP_B :
                       dw == `DW_HALF ? `STEP_H :
                       dw == `DW_WORD ? `STEP_W : `STEP_F;
    wire [25:0] nma = (cc[`B_UD] ? ca[25:0] + step
                                 : ca[25:0] - step) & amask;
    wire [31:0] pin = periph_data_i & wmask(dw);
    wire [3:0] wlast = {1'b0, wcnt} + 4'h1;
    wire pw_last = pcnt == wlast;
    // external wait freezes the count just before the final cycle
    wire stretch = pcnt == {1'b0, wcnt} && periph_wait_i;
    wire ack_on = st == S_P2 || st == S_PW;
    wire busy = st == S_P1 || ack_on || (st == S_MEM && rw);
    wire cnt_end = cc[`B_CTE] && last_xfer;

    // ****************************************
    // request capture and arbitration
    // ****************************************
    wire [1:0] pend;
    wire [1:0] rdy;
    wire start = st == S_IDLE && |rdy;
    // channel two always wins a tie; a transfer is never preempted
    wire gsel = ~rdy[0];

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            localparam [0:0] CI = i;
            wire [1:0] src = ctl[i][`DRS_HI:`DRS_LO];
            wire [1:0] mode = ctl[i][`DRM_HI:`DRM_LO];
            wire mclr = wr && kind == `K_CTL && rch == CI &&
                        wval[`DRM_HI:`DRM_LO] != mode;
            assign rdy[i] = ctl[i][`B_EN] & pend[i] & ~ctl[i][`B_FLY] &
                            (src != `DRS_OFF);
            request_latch u_latch (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .req_i(transfer_request_lines_i[src]),
                .mode_i(mode),
                .ack_i(busy && ch == CI),
                .mode_clr_i(mclr),
                .take_i(start && gsel == CI),
                .pending_o(pend[i])
            );
        end
        for (i = 0; i < 4; i = i + 1) begin : g_ack
            localparam [1:0] K = i;
            assign transfer_acknowledge_lines_o[i] =
                ack_on && drs_cur == K && K != `DRS_OFF;
        end
    endgenerate

    // ****************************************
    // registers and transfer sequencer
    // ****************************************
    integer n;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdat <= 32'h00000000;
            st <= S_IDLE;
            ch <= 1'b0;
            phase <= 1'b0;
            pcnt <= 4'h0;
            data <= 32'h00000000;
            term_hit <= 1'b0;
            for (n = 0; n < 2; n = n + 1) begin
                ctl[n] <= `CTL_RST;
                adr[n] <= 32'h00000000;
                cnt[n] <= `CNT_ZERO;
                tcn[n] <= `CNT_ZERO;
                tad[n] <= 26'h0000000;
            end
        end else begin
            ack <= req & ~ack;
            if (req & ~ack)
                rdat <= rmux;
            if (wr) begin
                case (kind)
                    `K_CTL: ctl[rch] <= wval & `CTL_WMASK;
                    `K_ADR: adr[rch] <= wval;
                    `K_CNT: cnt[rch] <= wval[23:0];
                    `K_TCN: tcn[rch] <= wval[23:0];
                    `K_TAD: begin
                        tad[rch] <= wval[25:0];
                        ctl[rch][`B_QEN] <= 1'b1;
                        ctl[rch][`B_TTI] <= 1'b0;
                        ctl[rch][`B_CTI] <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (ack_on && cc[`B_TTE] && ~cc[`B_TERMINATE_OUTPUT_SELECT] &&
                transfer_terminate_line_i)
                term_hit <= 1'b1;
            case (st)
                S_IDLE: begin
                    if (start) begin
                        ch <= gsel;
                        phase <= 1'b0;
                        term_hit <= 1'b0;
                        st <= ctl[gsel][`B_RW] ? S_MEM : S_P1;
                    end
                end
                S_MEM: begin
                    if (mem_ack_i) begin
                        if (split && ~phase) begin
                            phase <= 1'b1;
                            if (rw)
                                data[31:16] <= mem_rdata_i[31:16];
                        end else begin
                            if (rw)
                                data <= split ?
                                    {data[31:16], mem_rdata_i[31:16]} :
                                    mem_rdata_i;
                            st <= rw ? S_P1 : S_END;
                        end
                    end
                end
                S_P1: st <= S_P2;
                S_P2: begin
                    pcnt <= 4'h0;
                    st <= S_PW;
                end
                S_PW: begin
                    if (pw_last) begin
                        if (~rw)
                            data <= pin;
                        phase <= 1'b0;
                        if (cc[`B_EXT])
                            st <= S_PX;
                        else
                            st <= rw ? S_END : S_MEM;
                    end else if (~stretch) begin
                        pcnt <= pcnt + 4'h1;
                    end
                end
                S_PX: st <= rw ? S_END : S_MEM;
                S_END: begin
                    cnt[ch] <= cn - `CNT_ONE;
                    adr[ch] <= (ca & ~am32) | ({6'h00, nma} & am32);
                    if (cnt_end)
                        ctl[ch][`B_CTI] <= 1'b1;
                    if (term_hit)
                        ctl[ch][`B_TTI] <= 1'b1;
                    if (cnt_end || term_hit) begin
                        if (cc[`B_QEN]) begin
                            // the queued transfer takes over the head
                            adr[ch] <= (ca & ~am32) |
                                       ({6'h00, tad[ch]} & am32);
                            cnt[ch] <= tcn[ch];
                            ctl[ch][`B_QEN] <= 1'b0;
                        end else begin
                            ctl[ch][`B_EN] <= 1'b0;
                        end
                    end
                    st <= S_IDLE;
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // bus, peripheral and memory outputs
    // ****************************************
    assign ack_o = ack;
    assign dat_o = rdat;

    assign chan2_chip_select_o = ack_on && ~ch && cc[`B_ACS];
    assign chan3_chip_select_o = ack_on && ch && cc[`B_ACS];
    assign peripheral_output_enable_o = ~rw && st == S_PW;
    assign peripheral_write_enable_o = rw && st == S_PW && ~pw_last;
    assign periph_addr_o = lm ? {20'h00000, ca[31:28]}
                              : {16'h0000, ca[31:24]};
    assign periph_data_o = data & wmask(dw);
    assign periph_data_oe_o = rw &&
        (st == S_P2 || st == S_PW || st == S_PX);

    // only driven while the final count is being acknowledged
    assign transfer_terminate_line_o = `TERM_ACTIVE;
    assign transfer_terminate_line_oe_o =
        ack_on && cc[`B_TERMINATE_OUTPUT_SELECT] && last_xfer;

    assign mem_req_o = st == S_MEM;
    assign mem_we_o = ~rw;
    assign mem_size_o = dw;
    assign mem_addr_o = (ca[25:0] & amask) +
                        (phase ? `STEP_H : `STEP_F);
    assign mem_wdata_o = split ?
        {(phase ? data[15:0] : data[31:16]), 16'h0000} : data;

endmodule // dma_xfer_channels

`default_nettype wire

// *** tb/dma_xfer_channels_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****
// port checker for the transfer channels
// ****
module dma_xfer_channels_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [3:0] transfer_acknowledge_lines_o,
    input wire logic chan2_chip_select_o,
    input wire logic chan3_chip_select_o,
    input wire logic peripheral_output_enable_o,
    input wire logic peripheral_write_enable_o,
    input wire logic [23:0] periph_addr_o,
    input wire logic periph_data_oe_o,
    input wire logic periph_wait_i,
    input wire logic transfer_terminate_line_oe_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire any_ack = |transfer_acknowledge_lines_o;
    sequence s_rd_go;
        $rose(any_ack) && !periph_data_oe_o;
    endsequence
    sequence s_wr_go;
        $rose(any_ack) && periph_data_oe_o;
    endsequence
    property p_bus_ack;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus ack late");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_one_ack;
        $onehot0(transfer_acknowledge_lines_o) &&
            !transfer_acknowledge_lines_o[0];
    endproperty
    a_one_ack: assert property (p_one_ack) else $error("ack lines");
    property p_cs;
        chan2_chip_select_o || chan3_chip_select_o |-> any_ack;
    endproperty
    a_cs: assert property (p_cs) else $error("select outside ack");
    property p_addr;
        any_ack |-> periph_addr_o[23:8] == 16'h0000;
    endproperty
    a_addr: assert property (p_addr) else $error("upper address");
    property p_rd;
        s_rd_go |=> peripheral_output_enable_o [*2];
    endproperty
    a_rd: assert property (p_rd) else $error("read enable late");
    property p_wr;
        s_wr_go |=> peripheral_write_enable_o && periph_data_oe_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe late");
    property p_excl;
        !(peripheral_output_enable_o && periph_data_oe_o);
    endproperty
    a_excl: assert property (p_excl) else $error("bus fight");
    property p_wait;
        peripheral_output_enable_o && periph_wait_i |=>
            peripheral_output_enable_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait ignored");
    property p_dir0;
        $fell(peripheral_output_enable_o) |-> ##[0:3] (mem_req_o && mem_we_o);
    endproperty
    a_dir0: assert property (p_dir0) else $error("no memory write");
    property p_term;
        transfer_terminate_line_oe_o |-> any_ack;
    endproperty
    a_term: assert property (p_term) else $error("terminate drive");
endmodule // dma_xfer_channels_monitor

bind dma_xfer_channels dma_xfer_channels_monitor i_mon (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .transfer_acknowledge_lines_o,
    .chan2_chip_select_o, .chan3_chip_select_o, .peripheral_output_enable_o,
    .peripheral_write_enable_o, .periph_addr_o, .periph_data_oe_o,
    .periph_wait_i, .transfer_terminate_line_oe_o, .mem_req_o, .mem_we_o
);
`default_nettype wire

// *** tb/periph_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****
// external peripheral on request, acknowledge and data lines
// ****
module periph_model #(
    parameter logic [31:0] RD_WORD = 32'h12345678
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] go_i,
    input wire logic term_en_i,
    input wire logic [3:0] ack_lines_i,
    input wire logic oe_i,
    input wire logic we_i,
    input wire logic [31:0] wdata_i,
    output logic [3:0] req_o,
    output logic [31:0] rdata_o,
    output logic wait_o,
    output logic term_o,
    output logic [31:0] got_o
);
    logic seen;
    always @(posedge clk_i) begin
        if (rst_i) begin
            req_o <= 4'h0;
            seen <= 1'b0;
            got_o <= 32'h00000000;
        end else begin
            // a request stands until acknowledged, four cycles or more
            if (|ack_lines_i)
                req_o <= req_o & ~ack_lines_i;
            else
                req_o <= req_o | go_i;
            seen <= oe_i | we_i;
            if (we_i) begin
                got_o <= wdata_i;
            end
        end
    end
    // one stretch cycle at the start of every strobe burst
    assign wait_o = (oe_i | we_i) & ~seen;
    // released bus shows the inverse so a late sample cannot match
    assign rdata_o = oe_i ? RD_WORD : ~RD_WORD;
    assign term_o = term_en_i & (|ack_lines_i);
endmodule // periph_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dma_xfer_consts.vh"
module tb;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, mem_ack_i, term_en;
    logic cs2, cs3, oe, pwe, pdoe, pwait, term_dev, term_oe, term_mdl;
    logic mreq, mwe, narrow;
    logic [3:0] sel_i, req_lines, ack_lines, go;
    logic [23:0] paddr;
    logic [25:0] maddr, mem_a;
    logic [1:0] msize;
    logic [31:0] adr_i, dat_i, dat_o, pdin, pdout, got, mwdata, mem_wd, q;
    logic [31:0] mrdata, pcap;
    int bad_count, check_count;
    dma_xfer_channels i_dma_xfer_channels (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o),
        .transfer_request_lines_i(req_lines),
        .transfer_acknowledge_lines_o(ack_lines),
        .chan2_chip_select_o(cs2), .chan3_chip_select_o(cs3),
        .peripheral_output_enable_o(oe), .peripheral_write_enable_o(pwe),
        .periph_addr_o(paddr), .periph_data_i(pdin), .periph_data_o(pdout),
        .periph_data_oe_o(pdoe), .periph_wait_i(pwait),
        .transfer_terminate_line_i(term_oe ? term_dev : term_mdl),
        .transfer_terminate_line_o(term_dev),
        .transfer_terminate_line_oe_o(term_oe), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_addr_o(maddr), .mem_size_o(msize),
        .mem_wdata_o(mwdata), .mem_rdata_i(mrdata),
        .mem_ack_i(mem_ack_i), .mem_narrow_i(narrow));
    periph_model i_periph_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .term_en_i(term_en),
        .ack_lines_i(ack_lines), .oe_i(oe), .we_i(pwe), .wdata_i(pdout),
        .req_o(req_lines), .rdata_o(pdin), .wait_o(pwait), .term_o(term_mdl),
        .got_o(got));
    // ****
    // memory answering one cycle after each request
    // ****
    always @(posedge clk_i) begin
        mem_ack_i <= mreq && !mem_ack_i && !rst_i;
        if (mem_ack_i) begin
            mem_a <= maddr;
            mem_wd <= mwdata;
        end
        if (oe || pwe)
            pcap <= {6'h00, cs3, cs2, paddr};
    end
    // read data names its own address so half order can be seen
    assign mrdata = {maddr[15:0], 16'hF00D};
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            bad_count++;
            complete_run;
        end
    endtask
    // polls the enable bit; a channel that never stops ends the run
    task wait_idle(input logic [31:0] a, output logic [31:0] r);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0, r);
            n++;
        end while (r[`B_EN] !== 1'b0 && n < 100);
        if (r[`B_EN] !== 1'b0) begin
            bad_count++;
            complete_run;
        end
    endtask
    task pulse(input logic [3:0] v);
        @(posedge clk_i);
        go <= v;
        @(posedge clk_i);
        go <= 4'h0;
    endtask
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, term_en} = 4'h0;
        narrow = 1'b0;
        adr_i = 32'h0;
        dat_i = 32'h0;
        sel_i = 4'h0;
        go = 4'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `OFF_C2CTL, 32'h0, q);
        check("ctl2 reset", q, `CTL_RST);
        wb(1'b0, 32'h80000070, 32'h0, q);
        check("unmapped", q, 32'h00000000);
        // read from peripheral, stopped by the terminate line
        wb(1'b1, `OFF_C2ADR, 32'hA5000100, q);
        wb(1'b1, `OFF_C2CNT, 32'h00000005, q);
        wb(1'b1, `OFF_C2CTL, 32'h000142C0, q);
        term_en <= 1'b1;
        pulse(4'h2);
        wait_idle(`OFF_C2CTL, q);
        check("ctl2 end", q, 32'h00014242);
        wb(1'b0, `OFF_C2CNT, 32'h0, q);
        check("cnt2", q, 32'h00000004);
        wb(1'b0, `OFF_C2ADR, 32'h0, q);
        check("adr2", q, 32'hA5000104);
        check("mem wr addr", {6'h00, mem_a}, 32'h00000100);
        check("mem wr data", mem_wd, 32'h12345678);
        check("periph addr", pcap, 32'h000000A5);
        // write to peripheral, count runs out on the only transfer
        term_en <= 1'b0;
        wb(1'b1, `OFF_C3ADR, 32'h5B000200, q);
        wb(1'b1, `OFF_C3CNT, 32'h00000000, q);
        wb(1'b1, `OFF_C3CTL, 32'h003D83A0, q);
        pulse(4'h4);
        wait_idle(`OFF_C3CTL, q);
        check("ctl3 end", q, 32'h003D8321);
        wb(1'b0, `OFF_C3CNT, 32'h0, q);
        check("cnt3", q, 32'h00FFFFFF);
        wb(1'b0, `OFF_C3ADR, 32'h0, q);
        check("adr3", q, 32'h5B000204);
        check("mem rd addr", {6'h00, mem_a}, 32'h00000200);
        check("periph data", got, 32'h0200F00D);
        check("select 3", pcap, 32'h0200005B);
        // narrow memory word to the peripheral on an edge request
        narrow <= 1'b1;
        wb(1'b1, `OFF_C2ADR, 32'h3C000300, q);
        wb(1'b1, `OFF_C2CNT, 32'h00000000, q);
        wb(1'b1, `OFF_C2CTL, 32'h000743A0, q);
        pulse(4'h2);
        wait_idle(`OFF_C2CTL, q);
        check("ctl2 edge end", q, 32'h00074321);
        check("mem half addr", {6'h00, mem_a}, 32'h00000302);
        check("narrow data", got, 32'h03000302);
        check("select 2", pcap, 32'h0100003C);
        complete_run;
    end
endmodule // tb
`default_nettype wire
